// [hw/adaptive_lowpass_and_digit_mask.sv]
// Adaptive single-pole low-pass filter with displayed-digit masking
`timescale 1ns/10ps
// Notes on behaviour
// - Readings are sign, five digits, two fractions
// - Bits 7:6 select how many digits show
// - Masking applies only to reading responses
// - Large-signal code comes from bits 5:3
// - Small-signal code comes from bits 2:0
// - Filter choice made after each new sample
// - Step over ten counts uses large constant
// - Step under ten counts uses small constant
// - Codes map off, then 1 to 64 seconds
// - Small code uses the same mapping
// - Time constant scales with enabled channels
// - Filter is first-order low-pass
// - Setup can be rewritten at any time
// - Factory setup: address 1, 300 baud, no parity
// - Echo follows bit 2 of channel byte
// - Channel count from enables, channel 0 always
module adaptive_lowpass_and_digit_mask #(
   parameter int SAMPLE_W = lpf_mask_pkg::SAMPLE_W
) (
   input wire logic mclk, // 100 MHz clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic sample_valid, // New converter sample, one cycle
   input wire logic signed [SAMPLE_W-1:0] sample_in, // Sample in hundredths
   input wire logic cfg_write, // Setup write accepted, one cycle
   input wire logic [7:0] cfg_filter_in, // New filter and digits byte
   input wire logic [7:0] cfg_channel_in, // New channel byte
   input wire logic resp_req, // Response request, one cycle
   input wire lpf_mask_pkg::resp_kind_t resp_kind, // Kind of response
   output logic [7:0] filter_and_digits_setup, // Filter byte readback
   output logic [7:0] channel_setup, // Channel byte readback
   output logic [7:0] link_setup, // Baud and parity byte
   output logic [7:0] address_setup, // Address byte
   output logic echo_enable, // Character echo on
   output logic signed [SAMPLE_W-1:0] filter_out, // Unmasked filter output
   output logic signed [SAMPLE_W-1:0] reading_out, // Response value
   output logic reading_valid, // Response value valid, one cycle
   output logic large_selected // Last update used large constant
);
   import lpf_mask_pkg::*;

   logic [7:0] filt_reg, filt_next, chan_reg, chan_next;
   logic signed [SAMPLE_W-1:0] y_reg, y_next, rd_reg, rd_next;
   logic rv_reg, rv_next, big_reg, big_next;

   // Step weight of one displayed-digit count in hundredths
   function automatic logic [SAMPLE_W-1:0] lsd_unit(input logic [1:0] m);
      case (m)
         DIG_4: lsd_unit = SAMPLE_W'(1000);
         DIG_5: lsd_unit = SAMPLE_W'(100);
         DIG_6: lsd_unit = SAMPLE_W'(10);
         default: lsd_unit = SAMPLE_W'(1);
      endcase
   endfunction : lsd_unit

   // Remove the masked trailing digits, truncating toward zero
   function automatic logic signed [SAMPLE_W-1:0] mask_digits(
      input logic signed [SAMPLE_W-1:0] v, input logic [1:0] m);
      logic signed [SAMPLE_W-1:0] u;
      u = $signed(lsd_unit(m));
      mask_digits = (v / u) * u;
   endfunction : mask_digits

   // Shift for a code: shift per code step plus channel scaling
   function automatic logic [5:0] tc_shift(input logic [2:0] code, input logic [2:0] nch);
      logic [5:0] base;
      base = 6'(code) + 6'(SHIFT_4CH);
      case (nch)
         3'd1: tc_shift = base - 6'd2;
         3'd2, 3'd3: tc_shift = base - 6'd1;
         default: tc_shift = base;
      endcase
   endfunction : tc_shift

   logic [2:0] n_chan;
   logic signed [SAMPLE_W-1:0] diff, adiff, thresh;
   logic [2:0] code_sel;
   logic [5:0] sh;

   always_comb begin
      n_chan = 3'd1 + 3'(chan_reg[CH1_EN_BIT]) + 3'(chan_reg[CH1_EN_BIT+1])
         + 3'(chan_reg[CH3_EN_BIT]);
      diff = sample_in - y_reg;
      adiff = diff[SAMPLE_W-1] ? -diff : diff;
      thresh = SAMPLE_W'($signed(lsd_unit(filt_reg[DIGITS_HI:DIGITS_LO])) * BIG_STEP_COUNTS);
      filt_next = filt_reg;
      chan_next = chan_reg;
      y_next = y_reg;
      big_next = big_reg;
      rd_next = rd_reg;
      rv_next = 1'b0;
      code_sel = filt_reg[SMALL_HI:SMALL_LO];
      if (adiff > thresh) begin
         code_sel = filt_reg[LARGE_HI:LARGE_LO];
      end
      // Equal to threshold stays on small constant
      sh = tc_shift(code_sel, n_chan);
      if (cfg_write) begin
         filt_next = cfg_filter_in;
         chan_next = cfg_channel_in;
      end
      if (sample_valid) begin
         big_next = adiff > thresh;
         if (code_sel == 3'd0) begin
            y_next = sample_in;
         end else begin
            y_next = y_reg + (diff >>> sh);
         end
      end
      if (resp_req) begin
         rv_next = 1'b1;
         if (resp_kind == RSP_READ || resp_kind == RSP_NEW) begin
            rd_next = mask_digits(y_reg, filt_reg[DIGITS_HI:DIGITS_LO]);
         end else begin
            rd_next = y_reg;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         filt_reg <= FILTER_SETUP_RESET;
         chan_reg <= CHANNEL_SETUP_RESET;
         y_reg <= '0;
         rd_reg <= '0;
         rv_reg <= 1'b0;
         big_reg <= 1'b0;
      end else begin
         filt_reg <= filt_next;
         chan_reg <= chan_next;
         y_reg <= y_next;
         rd_reg <= rd_next;
         rv_reg <= rv_next;
         big_reg <= big_next;
      end
   end

   logic [7:0] link_reg, addr_reg, link_next, addr_next;
   logic echo_reg, echo_next;
   always_comb begin
      link_next = link_reg;
      addr_next = addr_reg;
      echo_next = chan_next[ECHO_BIT];
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         link_reg <= LINK_SETUP_RESET;
         addr_reg <= ADDRESS_RESET;
         echo_reg <= 1'b0;
      end else begin
         link_reg <= link_next;
         addr_reg <= addr_next;
         echo_reg <= echo_next;
      end
   end

   assign filter_and_digits_setup = filt_reg;
   assign channel_setup = chan_reg;
   assign link_setup = link_reg;
   assign address_setup = addr_reg;
   assign echo_enable = echo_reg;
   assign filter_out = y_reg;
   assign reading_out = rd_reg;
   assign reading_valid = rv_reg;
   assign large_selected = big_reg;

   sequence s_write;
      cfg_write;
   endsequence
   sequence s_sample;
      sample_valid;
   endsequence
   // Sample at or above the held output
   sequence s_step_up;
      s_sample ##0 (diff >= 0);
   endsequence
   // Sample below the held output
   sequence s_step_down;
      s_sample ##0 (diff < 0);
   endsequence

   chk_cfg_write_takes: assert property (@(posedge mclk) disable iff (!rst_n)
      s_write |=> filt_reg == $past(cfg_filter_in))
      else $error("filter setup not taken");
   chk_echo_follows: assert property (@(posedge mclk) disable iff (!rst_n)
      s_write |=> echo_enable == $past(cfg_channel_in[ECHO_BIT]))
      else $error("echo bit not followed");
   chk_large_sel: assert property (@(posedge mclk) disable iff (!rst_n)
      s_sample ##0 (adiff > thresh) |=> large_selected)
      else $error("large constant not selected");
   chk_small_sel: assert property (@(posedge mclk) disable iff (!rst_n)
      s_sample ##0 (adiff <= thresh) |=> !large_selected)
      else $error("small constant not selected");
   chk_hold_no_sample: assert property (@(posedge mclk) disable iff (!rst_n)
      !sample_valid |=> $stable(filter_out))
      else $error("output moved without sample");
   chk_nofilt_pass: assert property (@(posedge mclk) disable iff (!rst_n)
      s_sample ##0 (code_sel == 3'd0) |=> filter_out == $past(sample_in))
      else $error("unfiltered code did not pass sample");
   chk_step_up_bound: assert property (@(posedge mclk) disable iff (!rst_n)
      s_step_up |=> filter_out >= $past(filter_out) && filter_out <= $past(sample_in))
      else $error("filter left the upward step range");
   chk_step_down_bound: assert property (@(posedge mclk) disable iff (!rst_n)
      s_step_down |=> filter_out <= $past(filter_out) && filter_out >= $past(sample_in))
      else $error("filter left the downward step range");
   chk_mask_seven: assert property (@(posedge mclk) disable iff (!rst_n)
      resp_req && filt_reg[DIGITS_HI:DIGITS_LO] == DIG_7 |=> reading_out == $past(filter_out))
      else $error("all-digit mode altered reading");
   chk_mask_four: assert property (@(posedge mclk) disable iff (!rst_n)
      resp_req && resp_kind == RSP_READ && filt_reg[DIGITS_HI:DIGITS_LO] == DIG_4
      |=> reading_out % 1000 == 0)
      else $error("four-digit mask failed");
   chk_other_unmasked: assert property (@(posedge mclk) disable iff (!rst_n)
      resp_req && resp_kind == RSP_OTHER |=> reading_out == $past(filter_out))
      else $error("other response was masked");
   chk_reading_holds: assert property (@(posedge mclk) disable iff (!rst_n)
      !resp_req |=> $stable(reading_out))
      else $error("reading moved without request");
   chk_resp_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
      resp_req |=> reading_valid ##1 (reading_valid == $past(resp_req)))
      else $error("response valid not one cycle");
   chk_factory_link: assert property (@(posedge mclk) disable iff (!rst_n)
      link_setup == LINK_SETUP_RESET && address_setup == ADDRESS_RESET)
      else $error("factory link setup changed");
endmodule : adaptive_lowpass_and_digit_mask

// [hw/lpf_mask_pkg.sv]
// Constants and types for the adaptive low-pass filter and digit mask
package lpf_mask_pkg;
   localparam int SAMPLE_W = 32;
   localparam int TC_CODE_W = 3;
   localparam int DIGITS_HI = 7;
   localparam int DIGITS_LO = 6;
   localparam int LARGE_HI = 5;
   localparam int LARGE_LO = 3;
   localparam int SMALL_HI = 2;
   localparam int SMALL_LO = 0;
   localparam int ECHO_BIT = 2;
   localparam int CH1_EN_BIT = 5;
   localparam int CH3_EN_BIT = 7;
   localparam logic [7:0] FILTER_SETUP_RESET = 8'hC2;
   localparam logic [7:0] CHANNEL_SETUP_RESET = 8'hE1;
   localparam logic [7:0] LINK_SETUP_RESET = 8'h07;
   localparam logic [7:0] ADDRESS_RESET = 8'h31;
   localparam int REPORT_CHARS = 7;
   localparam int SIGN_CHARS = 1;
   localparam int INT_DIGITS = 5;
   localparam int FRAC_DIGITS = 2;
   localparam int BIG_STEP_COUNTS = 10;
   localparam int SHIFT_4CH = 2;
   // Digit selection codes
   typedef enum logic [1:0] {
      DIG_4 = 2'b00,
      DIG_5 = 2'b01,
      DIG_6 = 2'b10,
      DIG_7 = 2'b11
   } digit_mode_t;
   typedef enum logic [1:0] {
      RSP_OTHER = 2'b00,
      RSP_READ = 2'b01,
      RSP_NEW = 2'b10
   } resp_kind_t;
endpackage : lpf_mask_pkg

// [verif/adaptive_lowpass_and_digit_mask_tb_top.sv]
// Self-checking testbench for the adaptive filter and digit mask
`timescale 1ns/10ps
module adaptive_lowpass_and_digit_mask_tb_top;
   import lpf_mask_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic sample_valid = 1'b0;
   logic signed [31:0] sample_in = '0;
   logic cfg_write, resp_req, echo_enable, reading_valid, large_selected;
   logic [7:0] cfg_filter_in, cfg_channel_in, filter_and_digits_setup;
   logic [7:0] channel_setup, link_setup, address_setup;
   resp_kind_t resp_kind;
   logic signed [31:0] filter_out, reading_out;
   int fail_count = 0;
   int samples_checked = 0;
   always #5 mclk = ~mclk;
   adaptive_lowpass_and_digit_mask adaptive_lowpass_and_digit_mask_inst (
      .mclk(mclk), .rst_n(rst_n), .sample_valid(sample_valid), .sample_in(sample_in),
      .cfg_write(cfg_write), .cfg_filter_in(cfg_filter_in), .cfg_channel_in(cfg_channel_in),
      .resp_req(resp_req), .resp_kind(resp_kind), .channel_setup(channel_setup),
      .filter_and_digits_setup(filter_and_digits_setup), .link_setup(link_setup),
      .address_setup(address_setup), .echo_enable(echo_enable), .filter_out(filter_out),
      .reading_out(reading_out), .reading_valid(reading_valid),
      .large_selected(large_selected));
   host_model host_model_inst (.mclk(mclk), .cfg_write(cfg_write), .resp_req(resp_req),
      .cfg_filter_in(cfg_filter_in), .cfg_channel_in(cfg_channel_in), .resp_kind(resp_kind));
   task automatic chk(input string nm, input logic signed [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %0d seen %0d", nm, exp, seen);
      end
   endtask : chk
   task automatic close_out();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   task automatic smp(input logic signed [31:0] v);
      @(negedge mclk);
      sample_in = v;
      sample_valid = 1'b1;
      @(negedge mclk);
      sample_valid = 1'b0;
   endtask : smp
   task automatic rd(input resp_kind_t k, input logic signed [31:0] exp);
      host_model_inst.request(k);
      chk("reading_valid", reading_valid, 1);
      chk("reading_out", reading_out, exp);
      @(negedge mclk);
      chk("reading_valid", reading_valid, 0);
      chk("reading_out", reading_out, exp);
   endtask : rd
   task automatic t_reset();
      chk("filter_setup", filter_and_digits_setup, 8'hC2);
      chk("channel_setup", channel_setup, 8'hE1);
      chk("link_setup", link_setup, 8'h07);
      chk("address_setup", address_setup, 8'h31);
      chk("echo_enable", echo_enable, 0);
      host_model_inst.setup(8'hC2, 8'hE5);
      chk("echo_enable", echo_enable, 1);
   endtask : t_reset
   task automatic t_adapt();
      host_model_inst.setup(8'hC1, 8'hE1);
      chk("filter_setup", filter_and_digits_setup, 8'hC1);
      smp(11);
      chk("filter_out", filter_out, 11);
      chk("large_selected", large_selected, 1);
      smp(21);
      chk("filter_out", filter_out, 12);
      chk("large_selected", large_selected, 0);
      smp(20);
      chk("filter_out", filter_out, 13);
      host_model_inst.setup(8'hC1, 8'h01);
      smp(22);
      chk("filter_out", filter_out, 17);
      host_model_inst.setup(8'hC1, 8'h21);
      chk("channel_setup", channel_setup, 8'h21);
      smp(25);
      chk("filter_out", filter_out, 19);
      host_model_inst.setup(8'hC1, 8'h61);
      smp(27);
      chk("filter_out", filter_out, 21);
   endtask : t_adapt
   task automatic t_mask();
      int e[4] = '{12000, 12300, 12340, 12345};
      for (int m = 0; m < 4; m++) begin
         host_model_inst.setup({m[1:0], 6'h00}, 8'hE1);
         smp(12345);
         rd(RSP_READ, e[m]);
         rd(RSP_NEW, e[m]);
      end
      host_model_inst.setup(8'h00, 8'hE1);
      smp(-12345);
      rd(RSP_READ, -12000);
      rd(RSP_OTHER, -12345);
   endtask : t_mask
   task automatic t_thresh();
      host_model_inst.setup(8'h47, 8'hE1);
      smp(12345);
      chk("large_selected", large_selected, 1);
      smp(13345);
      chk("filter_out", filter_out, 12346);
      chk("large_selected", large_selected, 0);
      smp(13347);
      chk("filter_out", filter_out, 13347);
   endtask : t_thresh
   initial begin
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      t_reset();
      t_adapt();
      t_mask();
      t_thresh();
      close_out();
   end
   initial begin
      #50us;
      fail_count++;
      close_out();
   end
endmodule : adaptive_lowpass_and_digit_mask_tb_top

// [verif/host_model.sv]
// Host side model issuing setup writes and response requests
`timescale 1ns/10ps
module host_model (
   input wire logic mclk, // Clock
   output logic cfg_write, // Setup write pulse
   output logic [7:0] cfg_filter_in, // Filter and digits byte
   output logic [7:0] cfg_channel_in, // Channel byte
   output logic resp_req, // Response request pulse
   output lpf_mask_pkg::resp_kind_t resp_kind // Kind of response
);
   import lpf_mask_pkg::*;
   initial begin
      cfg_write = 1'b0;
      cfg_filter_in = 8'hC2;
      cfg_channel_in = 8'hE1;
      resp_req = 1'b0;
      resp_kind = RSP_OTHER;
   end
   task automatic setup(input logic [7:0] f, input logic [7:0] c);
      @(negedge mclk);
      cfg_filter_in = f;
      cfg_channel_in = c;
      cfg_write = 1'b1;
      @(negedge mclk);
      cfg_write = 1'b0;
   endtask : setup
   task automatic request(input resp_kind_t k);
      @(negedge mclk);
      resp_kind = k;
      resp_req = 1'b1;
      @(negedge mclk);
      resp_req = 1'b0;
   endtask : request
endmodule : host_model
